/* common/ssob_defines.vh */
// Object indices, sub-indices, field positions and reset values of the servo object bank
`ifndef SSOB_DEFINES_VH
`define SSOB_DEFINES_VH

`define SSOB_IDX_P1_FALL 16'h60D6
`define SSOB_IDX_P2_EDGE 16'h60D7
`define SSOB_IDX_FWD_TQ 16'h60E0
`define SSOB_IDX_REV_TQ 16'h60E1
`define SSOB_IDX_TRK_ERR 16'h60F4
`define SSOB_IDX_VEL_DEM 16'h60FA
`define SSOB_IDX_POS_DEM 16'h60FC
`define SSOB_IDX_IN_STAT 16'h60FD
`define SSOB_IDX_OUT_DRV 16'h60FE

`define SSOB_SUB_ZERO 8'h00
`define SSOB_SUB_ONE 8'h01

`define SSOB_TQ_RESET 16'h0BB8
`define SSOB_CNT_RESET 16'h0000
`define SSOB_WORD_RESET 32'h00000000
`define SSOB_FLAG_RESET 1'b0

`define SSOB_BIT_INDEX 31
`define SSOB_BIT_PROBE2 27
`define SSOB_BIT_PROBE1 26
`define SSOB_BIT_BRAKE 25
`define SSOB_BIT_INPOS 24
`define SSOB_BIT_ESTOP 23
`define SSOB_RSV_HI_MSB 30
`define SSOB_RSV_HI_LSB 28
`define SSOB_RSV_MID_MSB 22
`define SSOB_RSV_MID_LSB 18
`define SSOB_GEN_MSB 17
`define SSOB_GEN_LSB 4
`define SSOB_BIT_RSV3 3
`define SSOB_BIT_HOME 2
`define SSOB_BIT_FWD_OT 1
`define SSOB_BIT_REV_OT 0

`endif

/* hdl/ssob_edge_counter.v */
// Wrapping edge-latch event counter
`timescale 1ns/1ns
`include "ssob_defines.vh"

module ssob_edge_counter #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Event and count
	input wire latch_evt,
	output reg [WIDTH-1:0] count
);

always @(posedge clk)
begin
	if (!rst_n)
		count <= `SSOB_CNT_RESET;
	else if (latch_evt)
		count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
end

endmodule

/* hdl/ssob_object_bank.v */
// Servo status object bank: probe counters, torque ceilings, monitors, I/O words
// Contract
// - Probe one falling-edge latch count, 16-bit read-only, resets to zero.
// - Probe two rising-edge latch count, 16-bit read-only, resets to zero, transmitted.
// - Probe two falling-edge latch count, read-only, resets to zero.
// - Writable forward torque ceiling, default 3000 tenths percent, clamps positive torque.
// - Writable reverse torque ceiling, default 3000, clamps negative torque.
// - Following error reported read-only, signed 32-bit, valid in position modes.
// - Position-loop velocity demand reported read-only, signed 32-bit, default zero.
// - Internal position demand reported read-only, signed 32-bit, default zero.
// - Status word upper bits: index, probes, brake, in-position, emergency stop.
// - Status word lower bits: general inputs at 4..17, home, overtravels.
// - Probe one rising-edge latched flag: zero not latched, one latched.
`timescale 1ns/1ns
`include "ssob_defines.vh"

module ssob_object_bank #(
	parameter CNT_W = 16
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Object access port
	input wire [15:0] obj_index,
	input wire [7:0] obj_sub,
	input wire obj_rd,
	input wire obj_wr,
	input wire [31:0] obj_wdata,
	output reg [31:0] obj_rdata,
	output reg obj_ack,
	output reg obj_err,
	// Probe latch events
	input wire probe_one_rise_evt,
	input wire probe_one_fall_evt,
	input wire probe_two_rise_evt,
	input wire probe_two_fall_evt,
	input wire probe_flag_clear,
	output reg probe_one_rise_latched,
	// Torque path
	input wire signed [16:0] torque_demand,
	output reg signed [16:0] torque_limited,
	// Servo loop monitors
	input wire position_mode_active,
	input wire signed [31:0] tracking_error_in,
	input wire signed [31:0] velocity_demand_in,
	input wire signed [31:0] position_demand_in,
	// Digital inputs
	input wire encoder_index,
	input wire probe_two_input,
	input wire probe_one_input,
	input wire brake_state,
	input wire in_position_or_speed_match,
	input wire emergency_stop,
	input wire [13:0] general_inputs,
	input wire home_switch,
	input wire forward_overtravel_input,
	input wire reverse_overtravel_input,
	// Physical outputs
	output reg [31:0] output_drive_word
);

////////////////////////////////////////////////////////////////////////////////
// Counters

wire [CNT_W-1:0] probe_one_fall_count;
wire [CNT_W-1:0] probe_two_rise_count;
wire [CNT_W-1:0] probe_two_fall_count;

ssob_edge_counter #(.WIDTH(CNT_W)) u_p1_fall (
	.clk(clk),
	.rst_n(rst_n),
	.latch_evt(probe_one_fall_evt),
	.count(probe_one_fall_count)
);

ssob_edge_counter #(.WIDTH(CNT_W)) u_p2_rise (
	.clk(clk),
	.rst_n(rst_n),
	.latch_evt(probe_two_rise_evt),
	.count(probe_two_rise_count)
);

ssob_edge_counter #(.WIDTH(CNT_W)) u_p2_fall (
	.clk(clk),
	.rst_n(rst_n),
	.latch_evt(probe_two_fall_evt),
	.count(probe_two_fall_count)
);

////////////////////////////////////////////////////////////////////////////////
// Probe one rising flag, set wins over clear

always @(posedge clk)
begin
	if (!rst_n)
		probe_one_rise_latched <= `SSOB_FLAG_RESET;
	else if (probe_one_rise_evt)
		probe_one_rise_latched <= 1'b1;
	else if (probe_flag_clear)
		probe_one_rise_latched <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Monitors and status word

reg [31:0] tracking_error_value;
reg [31:0] loop_velocity_demand;
reg [31:0] internal_position_target;
reg [31:0] input_status_word;
reg [31:0] next_status;

always @*
begin
	next_status = `SSOB_WORD_RESET;
	next_status[`SSOB_BIT_INDEX] = encoder_index;
	next_status[`SSOB_BIT_PROBE2] = probe_two_input;
	next_status[`SSOB_BIT_PROBE1] = probe_one_input;
	next_status[`SSOB_BIT_BRAKE] = brake_state;
	next_status[`SSOB_BIT_INPOS] = in_position_or_speed_match;
	next_status[`SSOB_BIT_ESTOP] = emergency_stop;
	next_status[`SSOB_GEN_MSB:`SSOB_GEN_LSB] = general_inputs;
	next_status[`SSOB_BIT_HOME] = home_switch;
	next_status[`SSOB_BIT_FWD_OT] = forward_overtravel_input;
	next_status[`SSOB_BIT_REV_OT] = reverse_overtravel_input;
end

always @(posedge clk)
begin
	if (!rst_n)
	begin
		tracking_error_value <= `SSOB_WORD_RESET;
		loop_velocity_demand <= `SSOB_WORD_RESET;
		internal_position_target <= `SSOB_WORD_RESET;
		input_status_word <= `SSOB_WORD_RESET;
	end
	else
	begin
		// Outside position-type modes the error has no meaning
		tracking_error_value <= position_mode_active ? tracking_error_in
			: `SSOB_WORD_RESET;
		loop_velocity_demand <= velocity_demand_in;
		internal_position_target <= position_demand_in;
		input_status_word <= next_status;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Torque ceilings and clamp

reg [15:0] forward_torque_ceiling;
reg [15:0] reverse_torque_ceiling;
wire signed [16:0] fwd_lim = $signed({1'b0, forward_torque_ceiling});
wire signed [16:0] rev_lim = -$signed({1'b0, reverse_torque_ceiling});

always @(posedge clk)
begin
	if (!rst_n)
		torque_limited <= 17'sh00000;
	else if (torque_demand > fwd_lim)
		torque_limited <= fwd_lim;
	else if (torque_demand < rev_lim)
		torque_limited <= rev_lim;
	else
		torque_limited <= torque_demand;
end

////////////////////////////////////////////////////////////////////////////////
// Object access

function hit;
	input [15:0] idx;
	input [7:0] sub;
	input [15:0] want_idx;
	input [7:0] want_sub;
	begin
		hit = (idx == want_idx) && (sub == want_sub);
	end
endfunction

reg [31:0] next_rdata;
reg next_ok;
reg next_rw;

always @*
begin
	next_rdata = `SSOB_WORD_RESET;
	next_ok = 1'b1;
	next_rw = 1'b0;
	if (hit(obj_index, obj_sub, `SSOB_IDX_P1_FALL, `SSOB_SUB_ZERO))
		next_rdata = {16'h0000, probe_one_fall_count};
	else if (hit(obj_index, obj_sub, `SSOB_IDX_P2_EDGE, `SSOB_SUB_ZERO))
		next_rdata = {16'h0000, probe_two_rise_count};
	else if (hit(obj_index, obj_sub, `SSOB_IDX_P2_EDGE, `SSOB_SUB_ONE))
		next_rdata = {16'h0000, probe_two_fall_count};
	else if (hit(obj_index, obj_sub, `SSOB_IDX_FWD_TQ, `SSOB_SUB_ZERO))
	begin
		next_rdata = {16'h0000, forward_torque_ceiling};
		next_rw = 1'b1;
	end
	else if (hit(obj_index, obj_sub, `SSOB_IDX_REV_TQ, `SSOB_SUB_ZERO))
	begin
		next_rdata = {16'h0000, reverse_torque_ceiling};
		next_rw = 1'b1;
	end
	else if (hit(obj_index, obj_sub, `SSOB_IDX_TRK_ERR, `SSOB_SUB_ZERO))
		next_rdata = tracking_error_value;
	else if (hit(obj_index, obj_sub, `SSOB_IDX_VEL_DEM, `SSOB_SUB_ZERO))
		next_rdata = loop_velocity_demand;
	else if (hit(obj_index, obj_sub, `SSOB_IDX_POS_DEM, `SSOB_SUB_ZERO))
		next_rdata = internal_position_target;
	else if (hit(obj_index, obj_sub, `SSOB_IDX_IN_STAT, `SSOB_SUB_ZERO))
		next_rdata = input_status_word;
	else if (hit(obj_index, obj_sub, `SSOB_IDX_OUT_DRV, `SSOB_SUB_ONE))
	begin
		next_rdata = output_drive_word;
		next_rw = 1'b1;
	end
	else
		next_ok = 1'b0;
end

wire do_wr = obj_wr && next_ok && next_rw;

always @(posedge clk)
begin
	if (!rst_n)
	begin
		forward_torque_ceiling <= `SSOB_TQ_RESET;
		reverse_torque_ceiling <= `SSOB_TQ_RESET;
		output_drive_word <= `SSOB_WORD_RESET;
		obj_rdata <= `SSOB_WORD_RESET;
		obj_ack <= 1'b0;
		obj_err <= 1'b0;
	end
	else
	begin
		obj_ack <= obj_rd | obj_wr;
		// Unmapped index or sub-index, or write to a read-only object
		obj_err <= (obj_rd | obj_wr) & (~next_ok | (obj_wr & ~next_rw));
		if (obj_rd && next_ok)
			obj_rdata <= next_rdata;
		else if (obj_rd | obj_wr)
			obj_rdata <= `SSOB_WORD_RESET;
		if (do_wr && obj_index == `SSOB_IDX_FWD_TQ)
			forward_torque_ceiling <= obj_wdata[15:0];
		if (do_wr && obj_index == `SSOB_IDX_REV_TQ)
			reverse_torque_ceiling <= obj_wdata[15:0];
		if (do_wr && obj_index == `SSOB_IDX_OUT_DRV)
			output_drive_word <= obj_wdata;
	end
end

endmodule

/* testbench/ssob_master_model.sv */
// Fieldbus master model issuing one object request per call
`timescale 1ns/1ns
module ssob_master_model (
	// Answer side
	input wire clk,
	input wire obj_ack,
	input wire obj_err,
	input wire [31:0] obj_rdata,
	// Request side
	output logic [15:0] obj_index,
	output logic [7:0] obj_sub,
	output logic obj_rd,
	output logic obj_wr,
	output logic [31:0] obj_wdata
);
	logic [33:0] resp;
	initial
		{obj_index, obj_sub, obj_rd, obj_wr, obj_wdata} = '0;
	// Released index and data lines show the inverse of the last value; sub-index holds, rd and wr drop to zero
	task xfer(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
		@(posedge clk) #1;
		{obj_wr, obj_rd, obj_index, obj_sub, obj_wdata} = {w, !w, i, s, d};
		@(posedge clk) #1;
		{obj_wr, obj_rd, obj_index, obj_wdata} = {2'h0, ~i, ~d};
		resp = {obj_ack, obj_err, obj_rdata};
	endtask
endmodule

/* testbench/ssob_object_bank_monitor.sv */
// Port assertions for the servo object bank
`timescale 1ns/1ns
module ssob_object_bank_monitor (
	// Clock, reset and object port
	input wire clk,
	input wire rst_n,
	input wire obj_rd,
	input wire obj_wr,
	input wire obj_ack,
	input wire obj_err,
	input wire [31:0] obj_rdata,
	// Probe flag and torque
	input wire probe_one_rise_evt,
	input wire probe_flag_clear,
	input wire probe_one_rise_latched,
	input wire signed [16:0] torque_demand,
	input wire signed [16:0] torque_limited
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence req_s;
		obj_rd || obj_wr;
	endsequence
	ack_req_a: assert property (req_s |=> obj_ack) else $error("no ack");
	ack_cause_a: assert property (obj_ack |-> $past(obj_rd || obj_wr)) else $error("stray ack");
	err_zero_a: assert property (obj_err |-> obj_ack && obj_rdata == 0) else $error("bad err");
	flag_set_a: assert property (probe_one_rise_evt |=> probe_one_rise_latched)
		else $error("flag not set");
	flag_clr_a: assert property (probe_flag_clear && !probe_one_rise_evt |=>
		!probe_one_rise_latched) else $error("flag not cleared");
	flag_keep_a: assert property (!probe_one_rise_evt && !probe_flag_clear |=>
		$stable(probe_one_rise_latched)) else $error("flag moved");
	pos_clamp_a: assert property (torque_demand >= 0 |=> torque_limited >= 0 &&
		torque_limited <= $past(torque_demand)) else $error("pos clamp");
	neg_clamp_a: assert property (torque_demand < 0 |=> torque_limited <= 0 &&
		torque_limited >= $past(torque_demand)) else $error("neg clamp");
endmodule
bind ssob_object_bank ssob_object_bank_monitor mon (.*);

/* testbench/ssob_object_bank_tb_top.sv */
// Randomised self-checking bench for the servo object bank
`timescale 1ns/1ns
module ssob_object_bank_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, p1r, p1f, p2r, p2f, clr, pm;
	logic signed [16:0] tq, f, r;
	logic [31:0] te, ve, pe, n;
	logic [22:0] din;
	int seed = 32'hCF48, miscompares = 0, total_checks = 0;
	wire [15:0] obj_index;
	wire [7:0] obj_sub;
	wire obj_rd, obj_wr, obj_ack, obj_err, lat;
	wire [31:0] obj_wdata, obj_rdata, odw;
	wire signed [16:0] tql;
	always #50 clk = ~clk;
	ssob_master_model m (.*);
	ssob_object_bank uut (.*, .probe_one_rise_evt(p1r), .probe_one_fall_evt(p1f),
		.probe_two_rise_evt(p2r), .probe_two_fall_evt(p2f), .probe_flag_clear(clr),
		.probe_one_rise_latched(lat), .torque_demand(tq), .torque_limited(tql),
		.position_mode_active(pm), .tracking_error_in(te), .velocity_demand_in(ve),
		.position_demand_in(pe), .encoder_index(din[22]), .probe_two_input(din[21]),
		.probe_one_input(din[20]), .brake_state(din[19]), .in_position_or_speed_match(din[18]),
		.emergency_stop(din[17]), .home_switch(din[16]), .forward_overtravel_input(din[15]),
		.reverse_overtravel_input(din[14]), .general_inputs(din[13:0]), .output_drive_word(odw));
	function automatic logic signed [16:0] lim(input logic signed [16:0] d);
		return d > f ? f : (d < -r ? -r : d);
	endfunction
	task chk(input logic [33:0] got, exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask
	task rdchk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x, input logic e = 0);
		m.xfer(1'b0, i, s, 32'h0);
		chk(m.resp, {1'b1, e, x});
	endtask
	task stop_test;
		$display("%0d checks %0d mismatches", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		{p1r, p1f, p2r, p2f, clr, pm, tq, te, ve, pe, din} = '0;
		repeat (12) @(posedge clk) #1;
		rst_n = 1'b1;
		rdchk(16'h60E0, 8'h0, 32'hBB8);
		rdchk(16'h60E1, 8'h0, 32'hBB8);
		rdchk(16'h60D6, 8'h1, 32'h0, 1'b1);
		m.xfer(1'b1, 16'h60D6, 8'h0, 32'h5);
		chk(m.resp, {2'h3, 32'h0});
		n = 1 + ($random(seed) & 32'h3FF);
		p1f = 1'b1;
		for (int i = 0; i < 65537; i++)
		begin
			{p2r, p2f, p1r, clr} = {i < n, i < 65535, 2'($random(seed))};
			@(posedge clk) #1;
		end
		// Clear alone, then set and clear together: set wins
		{p1f, p1r, clr} = 3'h1;
		@(posedge clk) #1;
		chk(34'(lat), 34'h0);
		{p1r, clr} = 2'h3;
		@(posedge clk) #1;
		chk(34'(lat), 34'h1);
		{p1r, clr} = 2'h0;
		rdchk(16'h60D6, 8'h0, 32'h1);
		rdchk(16'h60D7, 8'h0, n);
		rdchk(16'h60D7, 8'h1, 32'hFFFF);
		// Reset in mid-run clears counters and flag
		rst_n = 1'b0;
		repeat (2) @(posedge clk) #1;
		rst_n = 1'b1;
		chk(34'(lat), 34'h0);
		rdchk(16'h60D6, 8'h0, 32'h0);
		rdchk(16'h60D7, 8'h1, 32'h0);
		for (int c = 0; c < 3; c++)
		begin
			{f, r} = c ? {1'b0, 16'($random(seed)), 1'b0, 16'($random(seed))} : '0;
			m.xfer(1'b1, 16'h60E0, 8'h0, 32'(f));
			chk(m.resp, {2'h2, 32'h0});
			m.xfer(1'b1, 16'h60E1, 8'h0, 32'(r));
			chk(m.resp, {2'h2, 32'h0});
			rdchk(16'h60E0, 8'h0, 32'(f));
			rdchk(16'h60E1, 8'h0, 32'(r));
			repeat (40)
			begin
				tq = 17'($random(seed));
				@(posedge clk) #1;
				chk(34'(tql), 34'(lim(tq)));
			end
		end
		for (int j = 0; j < 4; j++)
		begin
			din = j ? 23'($random(seed)) : '1;
			{te, ve, pe, pm} = {$random(seed), $random(seed), $random(seed), j[0]};
			n = {din[22], 3'h0, din[21:17], 5'h0, din[13:0], 1'b0, din[16:14]};
			rdchk(16'h60FD, 8'h0, n);
			rdchk(16'h60F4, 8'h0, pm ? te : 32'h0);
			rdchk(16'h60FA, 8'h0, ve);
			rdchk(16'h60FC, 8'h0, pe);
		end
		// Output word: store, read back, refuse the wrong sub-index
		n = $random(seed);
		m.xfer(1'b1, 16'h60FE, 8'h1, n);
		chk(m.resp, {2'h2, 32'h0});
		chk(34'(odw), 34'(n));
		rdchk(16'h60FE, 8'h1, n);
		m.xfer(1'b1, 16'h60FE, 8'h0, ~n);
		chk(m.resp, {2'h3, 32'h0});
		chk(34'(odw), 34'(n));
		stop_test();
	end
endmodule
